/* rla_core.sv */
// Link parameters, receive filter, wake-up preamble timing and flow control
//
// Summary of operation
// - Last packet signal strength readable, clamped to 0x25..0x6A.
// - 16-bit destination address, reset zero, must match to deliver payload.
// - Mismatched packets are still tracked but payload is dropped.
// - Network identifier, channel and address must all match for delivery.
// - Force command puts a preamble before the very next transmission.
// - Soft flow on: host 0x13 pauses and 0x11 resumes output.
// - Clear-to-send always gates host data; host obeys it.
// - Channel 0..6 hopping or 0..0x18 single frequency, reset zero.
// - Idle time counted in 100 ms; expiry arms a long preamble.
// - Idle period 0xFFFF never arms the long preamble.
// - Hardware version is read only; writes are ignored.
// - Network identifier writable up to 0x7FFF only.
// - Preamble ends on the preamble_length-th 100 ms tick after it starts.
// - Receiver needs 35 ms of initializer before it syncs.
// - Cyclic sleeper sleeps after idle, wakes periodically to listen.
// - Sleep mode 0..8 accepted; 0..2 never sleep, 3..8 cyclic 0.5..16 s.
`timescale 1ns/100ps
module rla_core
	import rla_pkg::*;
#(
	parameter int          TICK_CYCLES = rla_pkg::TICK_CYC,
	parameter int          WAKE_CYCLES = rla_pkg::WAKE_DET_CYC,
	parameter logic [15:0] HW_VERSION  = 16'h0001, // Arbitrary value
	parameter logic [15:0] NETID_RST   = 16'h0101  // Arbitrary value
) (
	// Clock and reset
	input  wire logic                  sys_clk_in,
	input  wire logic                  reset_in,
	// Command port
	input  wire logic                  cmd_valid_in,
	input  wire rla_pkg::rla_cmd_t     cmd_in,
	output logic                       rsp_valid_out,
	output logic [15:0]                rsp_data_out,
	input  wire logic                  single_freq_in,
	// Host serial into the modem
	input  wire logic                  host_valid_in,
	input  wire logic [7:0]            host_data_in,
	output logic                       cts_out,
	// Serial out to the host
	output logic                       ser_valid_out,
	output logic [7:0]                 ser_data_out,
	input  wire logic                  ser_ready_in,
	// Radio receive
	input  wire logic                  rf_hdr_valid_in,
	input  wire rla_pkg::rla_hdr_t     rf_hdr_in,
	input  wire logic                  rf_rx_valid_in,
	input  wire logic [7:0]            rf_rx_data_in,
	output logic                       rf_rx_ready_out,
	input  wire logic                  rf_wakeup_in,
	// Radio transmit
	output logic                       rf_tx_valid_out,
	output logic [7:0]                 rf_tx_data_out,
	input  wire logic                  rf_tx_ready_in,
	output logic                       preamble_out,
	// Status
	output logic                       rx_synced_out,
	output logic                       sleep_out
);
	import rla_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int WW = $clog2(WAKE_CYCLES + 1);

	logic [7:0]  rx_signal_strength, soft_flow_select, channel_number;
	logic [15:0] destination_address, idle_before_preamble, network_identifier, time_before_sleep;
	logic [7:0]  preamble_length;
	logic [3:0]  sleep_mode_select;
	logic        force_pend;
	logic [7:0]  next_rssi, next_flow, next_chan, next_pre_len;
	logic [15:0] next_dest, next_idle_pre, next_netid, next_sleep_time;
	logic [3:0]  next_sleep_mode;
	logic        next_force_pend, next_rsp_valid;
	logic [15:0] next_rsp_data;
	logic        wr;

	logic [TW-1:0] tick_cnt, next_tick_cnt;
	logic          tick;
	logic [15:0]   idle_ticks, next_idle_ticks;
	logic          activity;

	rla_tx_t       tx_state, next_tx_state;
	logic [7:0]    tx_hold, next_tx_hold, pre_ticks, next_pre_ticks;
	logic          tx_hold_v, next_tx_hold_v, paused, next_paused;
	logic          host_take, host_flow_char, tx_start, need_pre;

	logic          rx_fwd, next_rx_fwd, hdr_acc, hdr_match;
	logic          buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;

	rla_sleep_t    sleep_state, next_sleep_state;
	logic [7:0]    slp_ticks, next_slp_ticks;
	logic [WW-1:0] wake_cnt, next_wake_cnt;
	logic          cyclic;

	assign wr = cmd_valid_in && cmd_in.write;

	// Parameter store and command answers
	always_comb begin
		next_rssi       = rx_signal_strength;
		next_dest       = destination_address;
		next_flow       = soft_flow_select;
		next_chan       = channel_number;
		next_idle_pre   = idle_before_preamble;
		next_netid      = network_identifier;
		next_pre_len    = preamble_length;
		next_sleep_time = time_before_sleep;
		next_sleep_mode = sleep_mode_select;
		next_force_pend = force_pend && !(tx_start && need_pre);
		if (hdr_acc) begin
			if (rf_hdr_in.rssi < RSSI_MIN)
				next_rssi = RSSI_MIN;
			else if (rf_hdr_in.rssi > RSSI_MAX)
				next_rssi = RSSI_MAX;
			else
				next_rssi = rf_hdr_in.rssi;
		end
		if (wr) begin
			unique case (cmd_in.param)
				P_DEST: next_dest = cmd_in.data;
				P_FLOW: if (cmd_in.data <= 16'(FLOW_ON))
					next_flow = cmd_in.data[7:0];
				P_CHAN: if (cmd_in.data <= 16'(single_freq_in ? CH_MAX_SINGLE : CH_MAX_HOP))
					next_chan = cmd_in.data[7:0];
				P_IDLE_PRE: next_idle_pre = cmd_in.data;
				P_NETID: if (cmd_in.data <= NETID_WR_MAX)
					next_netid = cmd_in.data;
				P_PRE_LEN: next_pre_len = cmd_in.data[7:0];
				P_SLEEP_TIME: next_sleep_time = cmd_in.data;
				P_SLEEP_MODE: if (cmd_in.data <= 16'(SLEEP_MODE_MAX))
					next_sleep_mode = cmd_in.data[3:0];
				P_FORCE_PRE: next_force_pend = 1'b1;
				default: ; // Read-only entries ignore writes
			endcase
		end
		next_rsp_valid = cmd_valid_in;
		unique case (cmd_in.param)
			P_RSSI:       next_rsp_data = {8'h00, rx_signal_strength};
			P_DEST:       next_rsp_data = destination_address;
			P_FLOW:       next_rsp_data = {8'h00, soft_flow_select};
			P_CHAN:       next_rsp_data = {8'h00, channel_number};
			P_IDLE_PRE:   next_rsp_data = idle_before_preamble;
			P_HWVER:      next_rsp_data = HW_VERSION;
			P_NETID:      next_rsp_data = network_identifier;
			P_PRE_LEN:    next_rsp_data = {8'h00, preamble_length};
			P_SLEEP_TIME: next_rsp_data = time_before_sleep;
			P_SLEEP_MODE: next_rsp_data = {12'h000, sleep_mode_select};
			default:      next_rsp_data = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			rx_signal_strength   <= RSSI_MIN;
			destination_address  <= DEST_RST;
			soft_flow_select     <= FLOW_RST;
			channel_number       <= CHAN_RST;
			idle_before_preamble <= IDLE_PRE_RST;
			network_identifier   <= NETID_RST;
			preamble_length      <= PRE_LEN_RST;
			time_before_sleep    <= SLEEP_TIME_RST;
			sleep_mode_select    <= SLEEP_MODE_RST;
			force_pend           <= 1'b0;
			rsp_valid_out        <= 1'b0;
			rsp_data_out         <= 16'h0000;
		end else begin
			rx_signal_strength   <= next_rssi;
			destination_address  <= next_dest;
			soft_flow_select     <= next_flow;
			channel_number       <= next_chan;
			idle_before_preamble <= next_idle_pre;
			network_identifier   <= next_netid;
			preamble_length      <= next_pre_len;
			time_before_sleep    <= next_sleep_time;
			sleep_mode_select    <= next_sleep_mode;
			force_pend           <= next_force_pend;
			rsp_valid_out        <= next_rsp_valid;
			rsp_data_out         <= next_rsp_data;
		end
	end

	// 100 ms tick and idle time
	assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));
	assign activity = host_take || (ser_valid_out && ser_ready_in) || hdr_acc
		|| (rf_rx_valid_in && rf_rx_ready_out) || (rf_tx_valid_out && rf_tx_ready_in);

	always_comb begin
		next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
		next_idle_ticks = idle_ticks;
		if (activity)
			next_idle_ticks = 16'h0000;
		else if (tick && idle_ticks != 16'hFFFF)
			next_idle_ticks = idle_ticks + 16'h0001;
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			tick_cnt   <= '0;
			idle_ticks <= 16'h0000;
		end else begin
			tick_cnt   <= next_tick_cnt;
			idle_ticks <= next_idle_ticks;
		end
	end

	// Transmit path with preamble and flow control
	assign cts_out = !tx_hold_v;
	assign host_take = host_valid_in && cts_out;
	assign host_flow_char = (soft_flow_select == FLOW_ON)
		&& (host_data_in == XON_CHAR || host_data_in == XOFF_CHAR);
	assign tx_start = host_take && !host_flow_char && tx_state == TX_IDLE;
	assign need_pre = force_pend || (idle_before_preamble != IDLE_NEVER
		&& idle_ticks >= idle_before_preamble);
	assign rf_tx_valid_out = tx_hold_v && tx_state == TX_DATA;
	assign rf_tx_data_out = tx_hold;
	assign preamble_out = (tx_state == TX_PRE);

	always_comb begin
		next_tx_state  = tx_state;
		next_tx_hold   = tx_hold;
		next_tx_hold_v = tx_hold_v && !(rf_tx_valid_out && rf_tx_ready_in);
		next_pre_ticks = pre_ticks;
		next_paused    = paused;
		if (host_take && host_flow_char)
			next_paused = (host_data_in == XOFF_CHAR);
		else if (host_take) begin
			next_tx_hold   = host_data_in;
			next_tx_hold_v = 1'b1;
		end
		unique case (tx_state)
			TX_IDLE: if (tx_start) begin
				next_pre_ticks = 8'h00;
				if (need_pre && preamble_length != 8'h00)
					next_tx_state = TX_PRE;
				else
					next_tx_state = TX_DATA;
			end
			TX_PRE: if (tick) begin
				next_pre_ticks = pre_ticks + 8'h01;
				if (pre_ticks + 8'h01 >= preamble_length)
					next_tx_state = TX_DATA;
			end
			TX_DATA: if (!tx_hold_v && !host_valid_in)
				next_tx_state = TX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			tx_state  <= TX_IDLE;
			tx_hold   <= 8'h00;
			tx_hold_v <= 1'b0;
			pre_ticks <= 8'h00;
			paused    <= 1'b0;
		end else begin
			tx_state  <= next_tx_state;
			tx_hold   <= next_tx_hold;
			tx_hold_v <= next_tx_hold_v;
			pre_ticks <= next_pre_ticks;
			paused    <= next_paused;
		end
	end

	// Receive filter; a dropped packet is still drained to stay in step
	assign hdr_acc = rf_hdr_valid_in && sleep_state == SL_AWAKE;
	assign hdr_match = rf_hdr_in.net_id == network_identifier
		&& rf_hdr_in.channel == channel_number
		&& rf_hdr_in.dest == destination_address;
	assign next_rx_fwd = hdr_acc ? hdr_match : rx_fwd;
	assign buf_in_valid = rf_rx_valid_in && rx_fwd;
	assign rf_rx_ready_out = rx_fwd ? buf_in_ready : 1'b1;
	assign ser_valid_out = buf_out_valid && !paused;
	assign buf_out_ready = ser_ready_in && !paused;

	rla_buf2 #(.WIDTH(8), .DEPTH(2)) u_rx_buf (
		.sys_clk_in   (sys_clk_in),
		.reset_in     (reset_in),
		.in_valid_in  (buf_in_valid),
		.in_data_in   (rf_rx_data_in),
		.in_ready_out (buf_in_ready),
		.out_valid_out(buf_out_valid),
		.out_data_out (ser_data_out),
		.out_ready_in (buf_out_ready)
	);

	// Cyclic sleep and wake-up detection
	assign cyclic = sleep_mode_select >= SLEEP_CYC_MIN;
	assign rx_synced_out = (wake_cnt == WW'(WAKE_CYCLES));
	assign sleep_out = (sleep_state == SL_SLEEP);

	always_comb begin
		next_sleep_state = sleep_state;
		next_slp_ticks = tick ? slp_ticks + 8'h01 : slp_ticks;
		next_wake_cnt = '0;
		if (rf_wakeup_in && sleep_state != SL_SLEEP)
			next_wake_cnt = rx_synced_out ? wake_cnt : wake_cnt + 1'b1;
		unique case (sleep_state)
			SL_AWAKE: if (cyclic && idle_ticks >= time_before_sleep && !activity) begin
				next_sleep_state = SL_SLEEP;
				next_slp_ticks = 8'h00;
			end
			SL_SLEEP: if (!cyclic) next_sleep_state = SL_AWAKE;
			else if (next_slp_ticks >= rla_cyc_ticks(sleep_mode_select)) begin
				next_sleep_state = SL_LISTEN;
				next_slp_ticks = 8'h00;
			end
			SL_LISTEN: if (rx_synced_out || !cyclic) next_sleep_state = SL_AWAKE;
			else if (next_slp_ticks >= LISTEN_TICKS && !rf_wakeup_in) begin
				next_sleep_state = SL_SLEEP;
				next_slp_ticks = 8'h00;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			sleep_state <= SL_AWAKE;
			slp_ticks   <= 8'h00;
			wake_cnt    <= '0;
			rx_fwd      <= 1'b0;
		end else begin
			sleep_state <= next_sleep_state;
			slp_ticks   <= next_slp_ticks;
			wake_cnt    <= next_wake_cnt;
			rx_fwd      <= next_rx_fwd;
		end
	end

	// Checks
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	a_rssi_clamp: assert property (hdr_acc |=> rx_signal_strength >= RSSI_MIN
		&& rx_signal_strength <= RSSI_MAX) else $error("rssi out of range");
	a_dest_write: assert property (wr && cmd_in.param == P_DEST |=>
		destination_address == $past(cmd_in.data)) else $error("dest not stored");
	a_mismatch_drop: assert property (hdr_acc && rf_hdr_in.dest != destination_address
		|=> !buf_in_valid && rf_rx_ready_out) else $error("mismatch forwarded");
	a_layer_netid: assert property (hdr_acc && (rf_hdr_in.net_id != network_identifier
		|| rf_hdr_in.channel != channel_number) |=> !rx_fwd) else $error("layer ignored");
	a_force_pre: assert property (tx_start && force_pend && preamble_length != 8'h00
		|=> preamble_out && !rf_tx_valid_out) else $error("no forced preamble");
	a_xoff_pause: assert property (host_take && soft_flow_select == FLOW_ON
		&& host_data_in == XOFF_CHAR |=> !ser_valid_out) else $error("xoff ignored");
	a_cts_block: assert property (host_take && !host_flow_char |=> !cts_out)
		else $error("cts not dropped");
	a_chan_range: assert property (channel_number <= CH_MAX_SINGLE)
		else $error("channel out of range");
	a_never_pre: assert property (tx_start && !force_pend
		&& idle_before_preamble == IDLE_NEVER |=> !preamble_out) else $error("preamble sent");
	a_hwver_read: assert property (cmd_valid_in && cmd_in.param == P_HWVER
		|=> rsp_valid_out && rsp_data_out == HW_VERSION) else $error("bad version");
	a_netid_limit: assert property (wr && cmd_in.param == P_NETID
		&& cmd_in.data > NETID_WR_MAX |=> $stable(network_identifier)) else $error("netid");
	a_listen_sync: assert property (sleep_state == SL_LISTEN && !rx_synced_out
		&& cyclic |=> sleep_state != SL_AWAKE) else $error("woke without sync");

	c_forward: cover property (buf_in_valid ##1 ser_valid_out && ser_ready_in);
	c_preamble: cover property (preamble_out ##1 rf_tx_valid_out);
	c_sleep_wake: cover property (sleep_out ##[1:1000] sleep_state == SL_AWAKE);

endmodule

/* rla_pkg.sv */
// Shared types and constants for the radio link addressing and wake-up block
package rla_pkg;

	// Parameter selector of the command port
	typedef enum logic [3:0] {
		P_RSSI,
		P_DEST,
		P_FLOW,
		P_CHAN,
		P_IDLE_PRE,
		P_HWVER,
		P_NETID,
		P_PRE_LEN,
		P_SLEEP_TIME,
		P_SLEEP_MODE,
		P_FORCE_PRE
	} rla_param_t;

	typedef struct packed {
		logic       write;
		rla_param_t param;
		logic [15:0] data;
	} rla_cmd_t;

	// Header of a received packet, as decoded by the radio front end
	typedef struct packed {
		logic [15:0] net_id;
		logic [7:0]  channel;
		logic [15:0] dest;
		logic [7:0]  rssi;
	} rla_hdr_t;

	typedef enum {TX_IDLE, TX_PRE, TX_DATA} rla_tx_t;
	typedef enum {SL_AWAKE, SL_SLEEP, SL_LISTEN} rla_sleep_t;

	localparam logic [7:0]  RSSI_MIN       = 8'h25;
	localparam logic [7:0]  RSSI_MAX       = 8'h6A;
	localparam logic [7:0]  XON_CHAR       = 8'h11;
	localparam logic [7:0]  XOFF_CHAR      = 8'h13;
	localparam logic [7:0]  CH_MAX_HOP     = 8'h06;
	localparam logic [7:0]  CH_MAX_SINGLE  = 8'h18;
	localparam logic [15:0] NETID_WR_MAX   = 16'h7FFF;
	localparam logic [15:0] IDLE_NEVER     = 16'hFFFF;
	localparam logic [3:0]  SLEEP_MODE_MAX = 4'h8;
	localparam logic [3:0]  SLEEP_CYC_MIN  = 4'h3;
	localparam logic [7:0]  FLOW_ON        = 8'h01;
	localparam logic [15:0] DEST_RST       = 16'h0000;
	localparam logic [7:0]  FLOW_RST       = 8'h00;
	localparam logic [7:0]  CHAN_RST       = 8'h00;
	localparam logic [15:0] IDLE_PRE_RST   = 16'hFFFF;
	localparam logic [7:0]  PRE_LEN_RST    = 8'h01;
	localparam logic [15:0] SLEEP_TIME_RST = 16'h00C8;
	localparam logic [3:0]  SLEEP_MODE_RST = 4'h0;
	localparam logic [7:0]  LISTEN_TICKS   = 8'h01;

	// Timing in nanoseconds and the clock period they are counted in
	localparam int CLK_NS      = 100;
	localparam int TICK_NS     = 100_000_000;
	localparam int WAKE_DET_NS = 35_000_000;
	localparam int TICK_CYC    = TICK_NS / CLK_NS;
	localparam int WAKE_DET_CYC = (WAKE_DET_NS + CLK_NS - 1) / CLK_NS;

	// Cyclic sleep interval in 100 ms ticks for codes 3 to 8
	function automatic logic [7:0] rla_cyc_ticks(input logic [3:0] mode);
		logic [7:0] t;
		t = 8'h00;
		unique case (mode)
			4'h3: t = 8'h05;
			4'h4: t = 8'h0A;
			4'h5: t = 8'h14;
			4'h6: t = 8'h28;
			4'h7: t = 8'h50;
			4'h8: t = 8'hA0;
			default: t = 8'h05;
		endcase
		return t;
	endfunction

endpackage

/* rla_buf2.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module rla_buf2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             reset_in,
	// Fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// Drain side
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0]      count, next_count;
	logic             push, pop;

	assign in_ready_out  = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push)
			next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
		if (pop)
			next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage needs no reset; valid is gated by count
	always_ff @(posedge sys_clk_in) begin
		if (push)
			mem[wr_ptr] <= in_data_in;
	end

endmodule

/* rla_host_model.sv */
// Host model on the serial side of the modem
`timescale 1ns/100ps
module rla_host_model (
	// Clock and flow
	input  wire logic       sys_clk_in,
	input  wire logic       cts_in,
	// Host to modem
	output logic            host_valid_out,
	output logic [7:0]      host_data_out,
	// Modem to host
	input  wire logic       ser_valid_in,
	input  wire logic [7:0] ser_data_in,
	output logic            ser_ready_out
);
	logic       stall;
	logic       lost;
	logic [7:0] rxq[$];
	initial begin
		host_valid_out = 1'b0;
		host_data_out  = 8'h00;
		ser_ready_out  = 1'b1;
		stall          = 1'b0;
		lost           = 1'b0;
	end
	// Offer a byte only while clear-to-send is up
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 200; i++) begin
			@(negedge sys_clk_in);
			if (cts_in === 1'b1) begin
				host_valid_out = 1'b1;
				host_data_out  = b;
				@(negedge sys_clk_in);
				host_valid_out = 1'b0;
				// Released data is scrambled so stale values never match
				host_data_out  = ~b;
				return;
			end
		end
		lost = 1'b1;
	endtask
	// Take a byte at the edge on which the handshake completes
	always @(posedge sys_clk_in) begin
		if (ser_valid_in === 1'b1 && ser_ready_out === 1'b1)
			rxq.push_back(ser_data_in);
	end
	always @(negedge sys_clk_in) begin
		ser_ready_out <= ~stall;
	end
endmodule

/* tb_top.sv */
// Self-checking bench for the link parameter core
`timescale 1ns/100ps
module tb_top;
	import rla_pkg::*;
	logic        sys_clk_in, reset_in, cmd_valid_in, rsp_valid_out, single_freq_in;
	logic        host_valid, cts_out, ser_valid, ser_ready, rf_hdr_valid_in;
	logic        wake_in, tx_rdy, synced, sleeping;
	logic        rf_rx_valid_in, rf_rx_ready_out, rf_tx_valid_out, preamble_out;
	logic [7:0]  host_data, ser_data, rf_rx_data_in, rf_tx_data_out;
	logic [15:0] rsp_data_out, r;
	rla_cmd_t    cmd_in;
	rla_hdr_t    rf_hdr_in;
	int          fail_count, cmp_count, pre_cnt, n;
	logic [7:0]  txq[$];
	rla_param_t  rp[8] = '{P_DEST, P_FLOW, P_CHAN, P_IDLE_PRE, P_NETID, P_PRE_LEN,
		P_RSSI, P_HWVER};
	logic [15:0] rv[8] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0101,
		16'h0001, 16'h0025, 16'h0001};
	rla_param_t  wp[11] = '{P_DEST, P_HWVER, P_RSSI, P_NETID, P_NETID, P_FLOW,
		P_PRE_LEN, P_CHAN, P_CHAN, P_CHAN, P_CHAN};
	logic [15:0] wd[11] = '{16'hFFFF, 16'h1234, 16'h0050, 16'h8000, 16'h7FFF,
		16'h0002, 16'h0003, 16'h0007, 16'h0006, 16'h0018, 16'h0019};
	logic [15:0] we[11] = '{16'hFFFF, 16'h0001, 16'h0025, 16'h0101, 16'h7FFF,
		16'h0000, 16'h0003, 16'h0000, 16'h0006, 16'h0018, 16'h0018};
	rla_hdr_t    bh[3] = '{'{16'h7FFE, 8'h18, 16'hFFFF, 8'h10},
		'{16'h7FFF, 8'h17, 16'hFFFF, 8'h7F}, '{16'h7FFF, 8'h18, 16'hFFFE, 8'h40}};
	logic [15:0] be[3] = '{16'h0025, 16'h006A, 16'h0040};

	rla_core #(.TICK_CYCLES(10), .WAKE_CYCLES(4)) dut (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
		.rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
		.single_freq_in(single_freq_in),
		.host_valid_in(host_valid), .host_data_in(host_data), .cts_out(cts_out),
		.ser_valid_out(ser_valid), .ser_data_out(ser_data), .ser_ready_in(ser_ready),
		.rf_hdr_valid_in(rf_hdr_valid_in), .rf_hdr_in(rf_hdr_in),
		.rf_rx_valid_in(rf_rx_valid_in), .rf_rx_data_in(rf_rx_data_in),
		.rf_rx_ready_out(rf_rx_ready_out), .rf_wakeup_in(wake_in),
		.rf_tx_valid_out(rf_tx_valid_out), .rf_tx_data_out(rf_tx_data_out),
		.rf_tx_ready_in(tx_rdy), .preamble_out(preamble_out),
		.rx_synced_out(synced), .sleep_out(sleeping)
	);
	rla_host_model host (
		.sys_clk_in(sys_clk_in), .cts_in(cts_out),
		.host_valid_out(host_valid), .host_data_out(host_data),
		.ser_valid_in(ser_valid), .ser_data_in(ser_data), .ser_ready_out(ser_ready)
	);

	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	// Each edge with valid and ready high moves one byte to the radio
	always @(posedge sys_clk_in) begin
		if (rf_tx_valid_out === 1'b1 && tx_rdy === 1'b1) txq.push_back(rf_tx_data_out);
		if (preamble_out === 1'b1) pre_cnt++;
	end

	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic w, input rla_param_t p, input logic [15:0] d);
		@(negedge sys_clk_in);
		cmd_valid_in = 1'b1;
		cmd_in = {w, p, d};
		@(negedge sys_clk_in);
		cmd_valid_in = 1'b0;
		chk_bit(rsp_valid_out, 1'b1);
		r = rsp_data_out;
	endtask
	task automatic rd(input rla_param_t p, input logic [15:0] e);
		cmd(1'b0, p, 16'h0000);
		chk_val(r, e);
	endtask
	task automatic wait_len(input int k, input bit rx);
		for (int i = 0; i < 100; i++) begin
			if ((rx ? host.rxq.size() : txq.size()) >= k) return;
			@(negedge sys_clk_in);
		end
		fail_count++;
		$display("[ERR] %0t wait ran out", $time);
		stop_test();
	endtask
	task automatic hdr(input rla_hdr_t h);
		@(negedge sys_clk_in);
		rf_hdr_valid_in = 1'b1;
		rf_hdr_in = h;
		@(negedge sys_clk_in);
		rf_hdr_valid_in = 1'b0;
		rf_hdr_in = ~h;
	endtask
	task automatic rx(input logic [7:0] b);
		@(negedge sys_clk_in);
		rf_rx_valid_in = 1'b1;
		rf_rx_data_in = b;
		for (int i = 0; i < 100 && rf_rx_ready_out !== 1'b1; i++) @(negedge sys_clk_in);
		if (rf_rx_ready_out !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t radio byte refused", $time);
			stop_test();
		end
		@(negedge sys_clk_in);
		rf_rx_valid_in = 1'b0;
		rf_rx_data_in = ~b;
	endtask
	// Preamble length in cycles must fall within lo..hi
	task automatic tx_one(input logic [7:0] b, input int lo, input int hi);
		pre_cnt = 0;
		n = txq.size();
		host.send(b);
		wait_len(n + 1, 1'b0);
		chk_val({8'h00, txq[n]}, {8'h00, b});
		chk_bit(pre_cnt >= lo && pre_cnt <= hi, 1'b1);
	endtask

	initial begin
		reset_in = 1'b1;
		cmd_valid_in = 1'b0;
		cmd_in = '0;
		single_freq_in = 1'b0;
		rf_hdr_valid_in = 1'b0;
		rf_hdr_in = '0;
		rf_rx_valid_in = 1'b0;
		rf_rx_data_in = 8'h00;
		wake_in = 1'b0;
		tx_rdy = 1'b1;
		repeat (20) @(negedge sys_clk_in);
		reset_in = 1'b0;
		for (int i = 0; i < 8; i++) rd(rp[i], rv[i]);
		for (int i = 0; i < 11; i++) begin
			single_freq_in = (i > 8);
			cmd(1'b1, wp[i], wd[i]);
			rd(wp[i], we[i]);
		end
		repeat (30) @(negedge sys_clk_in);
		tx_one(8'h13, 0, 0);
		cmd(1'b1, P_FORCE_PRE, 16'h0001);
		tx_one(8'h5A, 21, 30);
		tx_one(8'hA5, 0, 0);
		cmd(1'b1, P_IDLE_PRE, 16'h0002);
		repeat (35) @(negedge sys_clk_in);
		tx_one(8'h3C, 21, 30);
		tx_one(8'hC3, 0, 0);
		// Radio stalls; the held byte stands and clear-to-send stays low
		n = txq.size();
		tx_rdy = 1'b0;
		host.send(8'h77);
		repeat (5) @(negedge sys_clk_in);
		chk_bit(cts_out, 1'b0);
		chk_val({8'h00, rf_tx_data_out}, 16'h0077);
		tx_rdy = 1'b1;
		wait_len(n + 1, 1'b0);
		chk_val({8'h00, txq[n]}, 16'h0077);
		for (int i = 0; i < 3; i++) begin
			hdr(bh[i]);
			chk_bit(rf_rx_ready_out, 1'b1);
			rx(8'hE0);
			repeat (5) @(negedge sys_clk_in);
			chk_val(16'(host.rxq.size()), 16'h0000);
			rd(P_RSSI, be[i]);
		end
		hdr('{16'h7FFF, 8'h18, 16'hFFFF, 8'h30});
		// Host stalls; two words fill the buffer, none lost
		host.stall = 1'b1;
		rx(8'h01);
		rx(8'h02);
		repeat (3) @(negedge sys_clk_in);
		chk_bit(rf_rx_ready_out, 1'b0);
		host.stall = 1'b0;
		rx(8'h03);
		wait_len(3, 1'b1);
		for (int i = 0; i < 3; i++) chk_val({8'h00, host.rxq[i]}, 16'(i + 1));
		cmd(1'b1, P_FLOW, 16'h0001);
		n = txq.size();
		host.send(8'h13);
		rx(8'h44);
		repeat (10) @(negedge sys_clk_in);
		chk_val(16'(host.rxq.size()), 16'h0003);
		host.send(8'h11);
		wait_len(4, 1'b1);
		chk_val({8'h00, host.rxq[3]}, 16'h0044);
		chk_val(16'(txq.size()), 16'(n));
		chk_bit(host.lost, 1'b0);
		// Preamble outlasts the sleep interval; idle period matches sleep time
		cmd(1'b1, P_PRE_LEN, 16'h0006);
		cmd(1'b1, P_SLEEP_TIME, 16'h0002);
		cmd(1'b1, P_SLEEP_MODE, 16'h0009);
		rd(P_SLEEP_MODE, 16'h0000);
		cmd(1'b1, P_SLEEP_MODE, 16'h0003);
		rd(P_SLEEP_MODE, 16'h0003);
		repeat (20) @(negedge sys_clk_in);
		chk_bit(sleeping, 1'b1);
		wake_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		chk_bit(synced, 1'b0);
		for (int i = 0; i < 100 && synced !== 1'b1; i++) @(negedge sys_clk_in);
		chk_bit(synced, 1'b1);
		chk_bit(sleeping, 1'b0);
		wake_in = 1'b0;
		stop_test();
	end
endmodule
